// >>> cecr_initiator.sv
/*
 * Remote node sending messages on the open-drain line.
 * Assumes a pull-up on the line and a tick clock at the sampling rate.
 */
`timescale 1ns/10ps
`default_nettype none

module cecr_initiator (
	input  wire logic tick_clk, // Sampling-rate clock
	input  wire logic line,     // Resolved line level
	output logic      pull_low  // High while pulling low
);
	logic ack_seen = 1'h1;

	initial pull_low = 1'h0;

	////////////////////////////////////////////////////////////
	task automatic wait_ticks(input int n);
		repeat (n) @(posedge tick_clk);
	endtask

	// Releases the line early; a follower may stretch the low
	// Whole bit lasts tot ticks whatever lo is; line looked at on tick 34
	task automatic send_bit(input int lo, input int tot);
		pull_low <= 1'h1;
		for (int t = 0; t < tot; t++) begin
			@(posedge tick_clk);
			if (t == lo - 1) pull_low <= 1'h0;
			if (t == 33) ack_seen = line;
		end
	endtask

	task automatic start();
		pull_low <= 1'h1;
		wait_ticks(121);
		pull_low <= 1'h0;
		wait_ticks(27);
	endtask

	// Ack bit is sent as one so the follower can pull it low
	task automatic block(input logic [7:0] b, input logic end_of_message_bit);
		for (int i = 7; i >= 0; i--) begin
			send_bit(b[i] ? 20 : 49, 79);
		end
		send_bit(end_of_message_bit ? 20 : 49, 79);
		send_bit(20, 79);
	endtask
endmodule // cecr_initiator

`default_nettype wire

// >>> cecr_pkg.sv
/*
 * Constants for the single-wire control bus receiver: register map,
 * field positions, reset values and timing in sampling-clock periods.
 * Assumes a 32-bit AXI4-Lite register bus and a sampling clock of 32.768 kHz.
 */
`default_nettype none

package cecr_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_FSSEL = 8'h00;
	localparam logic [7:0] OFS_EN    = 8'h04;
	localparam logic [7:0] OFS_SRST  = 8'h08;
	localparam logic [7:0] OFS_ADDR  = 8'h0c;
	localparam logic [7:0] OFS_RCTL1 = 8'h10;
	localparam logic [7:0] OFS_RCTL3 = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_RBUF  = 8'h1c;

	// receive_control_one fields
	localparam int HNC_LSB    = 0;
	localparam int LNC_LSB    = 2;
	localparam int MIN_LSB    = 5;
	localparam int MAX_LSB    = 8;
	localparam int DAT_LSB    = 11;
	localparam int ACKDIS_BIT = 14;
	localparam int IHLD_BIT   = 15;
	localparam int TOUT_LSB   = 16;

	// receive_flags bits
	localparam int F_END = 0;
	localparam int F_STA = 1;
	localparam int F_MAX = 2;
	localparam int F_MIN = 3;
	localparam int F_OR  = 5;

	// receive_buffer layout
	localparam int RB_EOM_BIT = 8;
	localparam int RB_ACK_BIT = 9;

	// Reset values
	localparam logic [31:0] RST_FSSEL = 32'h0000_0000;
	localparam logic [31:0] RST_ZERO  = 32'h0000_0000;

	// Timing, in periods of the sampling clock fs; SAMPLE_HZ in hertz, the two low times in microseconds
	localparam int SAMPLE_HZ    = 32768;
	localparam int CYC_MIN_FS   = 67;
	localparam int CYC_MAX_FS   = 90;
	localparam int DAT_BASE_FS  = 34;
	localparam int START_MIN_FS = 121;
	localparam int START_MAX_FS = 155;
	localparam int TOUT_UNIT_FS = 90;
	localparam int ACK_LOW_US   = 1526;
	localparam int ERR_LOW_US   = 3630;
	localparam int ACK_LOW_FS   = ACK_LOW_US * SAMPLE_HZ / 1000000;
	localparam int ERR_LOW_FS   = ERR_LOW_US * SAMPLE_HZ / 1000000;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_BITS
	} cecr_state_t;

endpackage

`default_nettype wire

// >>> cecr_receiver.sv
/*
 * Receiver of a single-wire consumer-electronics control bus with its
 * AXI4-Lite register file, noise filter, bit timing, acknowledge drive
 * and error hold.
 * Assumes the line pin, the low-speed clock and the timer output are
 * synchronous levels at sys_clk; the open-drain line is resolved outside.
 */
// Chosen here: the placing of the registers and register access over AXI4-Lite.
// Notes on behaviour
// - Select bit 0 picks low-speed clock or timer
// - Line sampled by 32.768 kHz or timer output
// - Start sets flag; interrupt only when enabled
// - Full block stored with end and acknowledge
// - Stored acknowledge is the sampled line value
// - Blocks continue until end-of-message block finishes
// - Error interrupts, discards data, waits for start
// - Every set address bit is an own address
// - Broadcast always received; address 15 acknowledges it
// - Edges accepted after consecutive filtered sample counts
// - Filter sample count is field value plus one
// - Cycle limits 67 and 90, trimmed -4..+3
// - Bit decided at 34/fs, trimmed -8..+6 in steps of 2/fs
// - Header acked whenever its address bit is set, data unless inhibited
// - Acknowledge drives line low about 1.526 ms
// - Error hold defers max and overrun errors
// - Held error gives inverted acknowledge response
// - Held interrupt after acknowledge or timeout
// - Bit cycle measured between falling edges
// - Short cycle drives line low about 3.63 ms
`timescale 1ns/10ps
`default_nettype none

module cecr_receiver #(
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk,       // System clock, 50 MHz
	input  wire logic              rst_n,         // Synchronous reset, active low
	input  wire logic              lsclk,         // Low-speed clock level
	input  wire logic              timer_output,  // Timer output level
	input  wire logic              cec_in,        // Line level seen at the pin
	output logic                   cec_out,       // Line drive value, always low
	output logic                   cec_oe,        // High while pulling the line low
	output logic                   irq_start,     // Start detected pulse
	output logic                   irq_rx,        // Byte received pulse
	output logic                   irq_err,       // Receive error pulse
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // Write address
	input  wire logic              s_axi_awvalid, // Write address valid
	output logic                   s_axi_awready, // Write address ready
	input  wire logic [31:0]       s_axi_wdata,   // Write data
	input  wire logic [3:0]        s_axi_wstrb,   // Write byte strobes
	input  wire logic              s_axi_wvalid,  // Write data valid
	output logic                   s_axi_wready,  // Write data ready
	output logic [1:0]             s_axi_bresp,   // Write response
	output logic                   s_axi_bvalid,  // Write response valid
	input  wire logic              s_axi_bready,  // Write response ready
	input  wire logic [ADDR_W-1:0] s_axi_araddr,  // Read address
	input  wire logic              s_axi_arvalid, // Read address valid
	output logic                   s_axi_arready, // Read address ready
	output logic [31:0]            s_axi_rdata,   // Read data
	output logic [1:0]             s_axi_rresp,   // Read response
	output logic                   s_axi_rvalid,  // Read response valid
	input  wire logic              s_axi_rready   // Read response ready
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		// Bus slave
		logic                aw_have;
		logic [ADDR_W-1:0]   aw_addr;
		logic                w_have;
		logic [31:0]         w_data;
		logic [3:0]          w_strb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [1:0]          rresp;
		logic [31:0]         rdata;
		// Registers
		logic                fssel;
		logic                en;
		logic [15:0]         addr;
		logic [17:0]         rctl1;
		logic                sta_en;
		logic [5:0]          flags;
		logic [9:0]          rbuf;
		logic                rbuf_full;
		// Sampling and filter
		logic                clk_prev;
		logic                line_s1;
		logic                line_s2;
		logic                filt;
		logic [2:0]          fcnt;
		// Receiver
		cecr_pkg::cecr_state_t st;
		logic [8:0]          cnt;
		logic [3:0]          bidx;
		logic [7:0]          shreg;
		logic                end_of_message_bit;
		logic                header;
		logic [3:0]          dest;
		logic                hold;
		logic [6:0]          drv;
		logic                p_start;
		logic                p_rx;
		logic                p_err;
	} cecr_regs_t;

	cecr_regs_t s_q;
	cecr_regs_t s_d;

	function automatic logic [31:0] cecr_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic        tick;
		logic        clk_sel;
		logic [3:0]  need;
		logic        fall;
		logic [8:0]  min_lim;
		logic [8:0]  max_lim;
		logic [8:0]  dat_pt;
		logic [8:0]  tout_lim;
		logic        own;
		logic        ack_yes;
		logic        wr;
		logic        soft_rst;
		logic [5:0]  set_f;
		logic [5:0]  clr_f;
		logic [31:0] wv;
		logic [5:0]  ra;
		logic [5:0]  wa;
		logic        rd_buf;

		s_d      = s_q;
		set_f    = 6'h00;
		clr_f    = 6'h00;
		soft_rst = 1'b0;
		rd_buf   = 1'b0;
		wv       = 32'h0000_0000;
		s_d.p_start = 1'b0;
		s_d.p_rx    = 1'b0;
		s_d.p_err   = 1'b0;

		// Sampling tick on the chosen clock's rising edge
		clk_sel    = s_q.fssel ? timer_output : lsclk;
		s_d.clk_prev = clk_sel;
		tick       = clk_sel && !s_q.clk_prev;

		s_d.line_s1 = cec_in;
		s_d.line_s2 = s_q.line_s1;

		// Noise filter: flip after need consecutive opposite samples
		// Four bits wide so a field of 7 asks for 8 samples, not 0
		need = s_q.filt ? (4'(s_q.rctl1[cecr_pkg::LNC_LSB +: 3]) + 4'h1)
			: (4'(s_q.rctl1[cecr_pkg::HNC_LSB +: 2]) + 4'h1);
		fall = 1'b0;
		if (tick) begin
			if (s_q.line_s2 == s_q.filt) begin
				s_d.fcnt = 3'h0;
			end else if (4'(s_q.fcnt) + 4'h1 >= need) begin
				s_d.filt = s_q.line_s2;
				s_d.fcnt = 3'h0;
				fall     = s_q.filt;
			end else begin
				s_d.fcnt = s_q.fcnt + 3'h1;
			end
		end

		// Limits in sampling periods
		min_lim = 9'(cecr_pkg::CYC_MIN_FS)
			+ {{6{s_q.rctl1[cecr_pkg::MIN_LSB+2]}}, s_q.rctl1[cecr_pkg::MIN_LSB +: 3]};
		max_lim = 9'(cecr_pkg::CYC_MAX_FS)
			+ {{6{s_q.rctl1[cecr_pkg::MAX_LSB+2]}}, s_q.rctl1[cecr_pkg::MAX_LSB +: 3]};
		dat_pt  = 9'(cecr_pkg::DAT_BASE_FS)
			+ {{5{s_q.rctl1[cecr_pkg::DAT_LSB+2]}}, s_q.rctl1[cecr_pkg::DAT_LSB +: 3], 1'b0};
		tout_lim = 9'(cecr_pkg::TOUT_UNIT_FS
			* (int'(s_q.rctl1[cecr_pkg::TOUT_LSB +: 2]) + 1));

		own     = s_q.addr[s_q.dest] || (s_q.dest == 4'hf);
		ack_yes = s_q.addr[s_q.dest]
			&& (s_q.header || !s_q.rctl1[cecr_pkg::ACKDIS_BIT]);

		if (tick && s_q.drv != 7'h00) begin
			s_d.drv = s_q.drv - 7'h01;
		end
		if (tick && s_q.cnt != 9'h1ff) begin
			s_d.cnt = s_q.cnt + 9'h001;
		end

		////////////////////////////////////////////////////////////////////////
		// Receive sequencing

		case (s_q.st)
			cecr_pkg::ST_IDLE: begin
				if (fall && s_q.en) begin
					s_d.st  = cecr_pkg::ST_START;
					s_d.cnt = 9'h000;
				end
			end
			cecr_pkg::ST_START: begin
				if (fall) begin
					s_d.cnt = 9'h000;
					if (s_q.cnt >= 9'(cecr_pkg::START_MIN_FS)) begin
						set_f[cecr_pkg::F_STA] = 1'b1;
						s_d.p_start    = s_q.sta_en;
						s_d.st         = cecr_pkg::ST_BITS;
						s_d.bidx       = 4'h0;
						s_d.header     = 1'b1;
						s_d.hold       = 1'b0;
					end
				end else if (s_q.cnt > 9'(cecr_pkg::START_MAX_FS)) begin
					s_d.st = cecr_pkg::ST_IDLE;
				end
			end
			cecr_pkg::ST_BITS: begin
				if (fall) begin
					s_d.cnt = 9'h000;
					if (s_q.cnt < min_lim) begin
						// Not holdable: the line is claimed at once
						set_f[cecr_pkg::F_MIN] = 1'b1;
						s_d.p_err    = 1'b1;
						s_d.drv      = 7'(cecr_pkg::ERR_LOW_FS);
						s_d.st       = cecr_pkg::ST_IDLE;
					end else if (s_q.bidx == 4'h9) begin
						s_d.bidx   = 4'h0;
						s_d.header = 1'b0;
					end else begin
						s_d.bidx = s_q.bidx + 4'h1;
						// Edge already confirmed by the low filter
						if (s_q.bidx == 4'h8 && (ack_yes != s_q.hold)) begin
							s_d.drv = 7'(cecr_pkg::ACK_LOW_FS);
						end
					end
				end else if (tick && s_q.cnt == dat_pt) begin
					if (s_q.bidx < 4'h8) begin
						s_d.shreg = {s_q.shreg[6:0], s_q.filt};
						if (s_q.bidx == 4'h7 && s_q.header) begin
							s_d.dest = {s_q.shreg[2:0], s_q.filt};
						end
					end else if (s_q.bidx == 4'h8) begin
						s_d.end_of_message_bit = s_q.filt;
					end else if (s_q.hold) begin
						s_d.p_err = 1'b1;
						s_d.st    = cecr_pkg::ST_IDLE;
					end else if (!own) begin
						s_d.st = cecr_pkg::ST_IDLE;
					end else if (s_q.rbuf_full) begin
						set_f[cecr_pkg::F_OR] = 1'b1;
						if (s_q.rctl1[cecr_pkg::IHLD_BIT]) begin
							s_d.hold = 1'b1;
						end else begin
							s_d.p_err = 1'b1;
							s_d.st    = cecr_pkg::ST_IDLE;
						end
					end else begin
						s_d.rbuf      = {s_q.filt, s_q.end_of_message_bit, s_q.shreg};
						s_d.rbuf_full = 1'b1;
						set_f[cecr_pkg::F_END] = 1'b1;
						s_d.p_rx      = 1'b1;
						if (s_q.end_of_message_bit) begin
							s_d.st = cecr_pkg::ST_IDLE;
						end
					end
				end else if (tick && !s_q.hold && s_q.cnt == max_lim + 9'h001) begin
					set_f[cecr_pkg::F_MAX] = 1'b1;
					if (s_q.rctl1[cecr_pkg::IHLD_BIT]) begin
						s_d.hold = 1'b1;
					end else begin
						s_d.p_err = 1'b1;
						s_d.st    = cecr_pkg::ST_IDLE;
					end
				end else if (tick && s_q.hold && s_q.cnt == tout_lim) begin
					s_d.p_err = 1'b1;
					s_d.st    = cecr_pkg::ST_IDLE;
				end
			end
			default: begin
				s_d.st = cecr_pkg::ST_IDLE;
			end
		endcase

		if (!s_q.en) begin
			s_d.st   = cecr_pkg::ST_IDLE;
			s_d.drv  = 7'h00;
			s_d.hold = 1'b0;
		end

		////////////////////////////////////////////////////////////////////////
		// AXI4-Lite slave

		if (s_axi_awvalid && !s_q.aw_have) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_have) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		wa = s_q.aw_addr[7:2];
		wr = s_q.aw_have && s_q.w_have && !s_q.bvalid;
		if (wr) begin
			s_d.aw_have = 1'b0;
			s_d.w_have  = 1'b0;
			s_d.bvalid  = 1'b1;
			s_d.bresp   = 2'h0;
			case ({wa, 2'b00})
				cecr_pkg::OFS_FSSEL: begin
					wv = cecr_merge({31'h0, s_q.fssel}, s_q.w_data, s_q.w_strb);
					s_d.fssel = wv[0];
				end
				cecr_pkg::OFS_EN: begin
					wv = cecr_merge({31'h0, s_q.en}, s_q.w_data, s_q.w_strb);
					s_d.en = wv[0];
				end
				cecr_pkg::OFS_SRST: begin
					wv = cecr_merge(32'h0, s_q.w_data, s_q.w_strb);
					soft_rst = wv[0];
				end
				cecr_pkg::OFS_ADDR: begin
					wv = cecr_merge({16'h0, s_q.addr}, s_q.w_data, s_q.w_strb);
					s_d.addr = wv[15:0];
				end
				cecr_pkg::OFS_RCTL1: begin
					wv = cecr_merge({14'h0, s_q.rctl1}, s_q.w_data, s_q.w_strb);
					s_d.rctl1 = wv[17:0];
				end
				cecr_pkg::OFS_RCTL3: begin
					wv = cecr_merge({31'h0, s_q.sta_en}, s_q.w_data, s_q.w_strb);
					s_d.sta_en = wv[0];
				end
				cecr_pkg::OFS_FLAGS: begin
					wv = cecr_merge(32'h0, s_q.w_data, s_q.w_strb);
					clr_f = wv[5:0];
				end
				cecr_pkg::OFS_RBUF: begin
				end
				default: begin
					s_d.bresp = 2'h2;
				end
			endcase
		end

		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		ra = s_axi_araddr[7:2];
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = 2'h0;
			case ({ra, 2'b00})
				cecr_pkg::OFS_FSSEL: s_d.rdata = {31'h0, s_q.fssel};
				cecr_pkg::OFS_EN:    s_d.rdata = {31'h0, s_q.en};
				cecr_pkg::OFS_SRST:  s_d.rdata = 32'h0000_0000;
				cecr_pkg::OFS_ADDR:  s_d.rdata = {16'h0, s_q.addr};
				cecr_pkg::OFS_RCTL1: s_d.rdata = {14'h0, s_q.rctl1};
				cecr_pkg::OFS_RCTL3: s_d.rdata = {31'h0, s_q.sta_en};
				cecr_pkg::OFS_FLAGS: s_d.rdata = {26'h0, s_q.flags};
				cecr_pkg::OFS_RBUF: begin
					s_d.rdata = {22'h0, s_q.rbuf};
					rd_buf    = 1'b1;
				end
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = 2'h2;
				end
			endcase
		end

		// Hardware set wins over a clear in the same cycle
		s_d.flags = (s_q.flags & ~clr_f) | set_f;
		if (rd_buf && !(set_f[cecr_pkg::F_END])) begin
			s_d.rbuf_full = 1'b0;
		end

		if (soft_rst) begin
			s_d.fssel     = cecr_pkg::RST_FSSEL[0];
			s_d.en        = 1'b0;
			s_d.addr      = cecr_pkg::RST_ZERO[15:0];
			s_d.rctl1     = cecr_pkg::RST_ZERO[17:0];
			s_d.sta_en    = 1'b0;
			s_d.flags     = cecr_pkg::RST_ZERO[5:0];
			s_d.rbuf      = cecr_pkg::RST_ZERO[9:0];
			s_d.rbuf_full = 1'b0;
			s_d.st        = cecr_pkg::ST_IDLE;
			s_d.drv       = 7'h00;
			s_d.hold      = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_q       <= '0;
			s_q.filt  <= 1'b1;
			s_q.st    <= cecr_pkg::ST_IDLE;
			s_q.fssel <= cecr_pkg::RST_FSSEL[0];
			// Idle line level, so no false fall right after reset
			s_q.line_s1 <= 1'b1;
			s_q.line_s2 <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign cec_out       = 1'b0;
	assign cec_oe        = (s_q.drv != 7'h00);
	assign irq_start     = s_q.p_start;
	assign irq_rx        = s_q.p_rx;
	assign irq_err       = s_q.p_err;
	assign s_axi_awready = !s_q.aw_have;
	assign s_axi_wready  = !s_q.w_have;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;

endmodule // cecr_receiver

`default_nettype wire

// >>> cecr_receiver_properties.sv
/*
 * Port checker for the bus receiver, attached by bind.
 * Assumes only one of the two sample clocks toggles at a time.
 */
`timescale 1ns/10ps
`default_nettype none

module cecr_receiver_properties (
	input wire logic        sys_clk,       // Clock
	input wire logic        rst_n,         // Reset, low
	input wire logic        lsclk,         // Slow clock
	input wire logic        timer_output,  // Timer clock
	input wire logic        cec_in,        // Line level
	input wire logic        cec_out,       // Drive value
	input wire logic        cec_oe,        // Pull enable
	input wire logic        irq_start,     // Start pulse
	input wire logic        irq_rx,        // Byte pulse
	input wire logic        irq_err,       // Error pulse
	input wire logic        s_axi_awvalid, // Aw valid
	input wire logic        s_axi_awready, // Aw ready
	input wire logic        s_axi_wvalid,  // W valid
	input wire logic        s_axi_wready,  // W ready
	input wire logic        s_axi_bvalid,  // B valid
	input wire logic        s_axi_bready,  // B ready
	input wire logic [1:0]  s_axi_bresp,   // B code
	input wire logic        s_axi_arvalid, // Ar valid
	input wire logic        s_axi_arready, // Ar ready
	input wire logic        s_axi_rvalid,  // R valid
	input wire logic        s_axi_rready,  // R ready
	input wire logic [31:0] s_axi_rdata    // R data
);
	logic       ls_q;
	logic       tm_q;
	logic [7:0] cnt_q;

	// Sample ticks seen while the line is pulled
	always_ff @(posedge sys_clk) begin
		ls_q <= lsclk;
		tm_q <= timer_output;
		if (!rst_n || !cec_oe)
			cnt_q <= 8'h00;
		else if ((lsclk && !ls_q) || (timer_output && !tm_q))
			cnt_q <= cnt_q + 8'h01;
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////
	property p_line_value; cec_out == 1'h0; endproperty
	a_line_value: assert property (p_line_value) else $error("line driven high");
	property p_oe_len; $fell(cec_oe) |-> cnt_q inside {[48:52], [116:120]}; endproperty
	a_oe_len: assert property (p_oe_len) else $error("pull length wrong");
	property p_oe_cap; cec_oe |-> cnt_q < 8'h79; endproperty
	a_oe_cap: assert property (p_oe_cap) else $error("pull too long");
	property p_oe_on_low; $rose(cec_oe) |-> !$past(cec_in); endproperty
	a_oe_on_low: assert property (p_oe_on_low) else $error("pull without fall");
	property p_start_pulse; irq_start |=> !irq_start; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse long");
	property p_rx_pulse; irq_rx |=> !irq_rx; endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("byte pulse long");
	property p_err_pulse; irq_err |=> !irq_err; endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("error pulse long");
	property p_wr_lat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
	property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule // cecr_receiver_properties

bind cecr_receiver cecr_receiver_properties u_props (.sys_clk, .rst_n, .lsclk, .timer_output,
	.cec_in, .cec_out, .cec_oe, .irq_start, .irq_rx, .irq_err, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

`default_nettype wire

// >>> tb_top.sv
/*
 * Self-checking bench for the receiver: register bus tasks and messages
 * from a remote node. Assumes a sample tick every 6 system clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic        sys_clk = 1'h0;
	logic        rst_n   = 1'h0;
	logic        div     = 1'h0;
	logic [1:0]  dcnt    = 2'h0;
	logic        sel_tm  = 1'h0;
	logic [7:0]  awaddr  = 8'h00;
	logic [31:0] wdata   = 32'h0;
	logic        awvalid = 1'h0;
	logic        wvalid  = 1'h0;
	logic        bready  = 1'h0;
	logic [7:0]  araddr  = 8'h00;
	logic        arvalid = 1'h0;
	logic        rready  = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, bresp_seen;
	logic [31:0] rdata;
	logic        cec_in, cec_out, cec_oe, irq_start, irq_rx, irq_err;
	logic        far_low, lsclk, timer_output;
	int          miscompares = 0;
	int          n_tests = 0;
	int          n_st = 0;
	int          n_rx = 0;
	int          n_err = 0;

	assign lsclk = div & ~sel_tm;
	assign timer_output = div & sel_tm;
	assign cec_in = ~far_low & (cec_oe ? cec_out : 1'h1);

	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		dcnt <= (dcnt == 2'h2) ? 2'h0 : dcnt + 2'h1;
		if (dcnt == 2'h2) div <= ~div;
		if (irq_start) n_st++;
		if (irq_rx) n_rx++;
		if (irq_err) n_err++;
	end

	cecr_receiver uut (.sys_clk, .rst_n, .lsclk, .timer_output, .cec_in, .cec_out, .cec_oe,
		.irq_start, .irq_rx, .irq_err, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	cecr_initiator u_far (.tick_clk(div), .line(cec_in), .pull_low(far_low));

	////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n = 0;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			n++;
		end while (!bvalid && n < 50);
		bresp_seen = bresp;
		bready <= 1'h0;
		if (n >= 50) begin
			miscompares++;
			give_verdict();
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n = 0;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'h0;
			n++;
		end while (!rvalid && n < 50);
		v = rdata;
		rs = rresp;
		rready <= 1'h0;
		if (n >= 50) begin
			miscompares++;
			give_verdict();
		end
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rs);
		logic [31:0] v;
		logic [1:0]  g;
		rd(a, v, g);
		chk(v, exp);
		chk({30'h0, g}, {30'h0, rs});
	endtask

	task automatic blk(input logic [7:0] b, input logic end_of_message_bit, input logic ack);
		u_far.block(b, end_of_message_bit);
		chk({31'h0, u_far.ack_seen}, {31'h0, ack});
	endtask

	initial begin
		repeat (98000) @(posedge sys_clk);
		miscompares++;
		give_verdict();
	end

	////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'h1;
		rchk(cecr_pkg::OFS_FSSEL, cecr_pkg::RST_FSSEL, 2'h0);
		rchk(8'h40, 32'h0, 2'h2);
		wr(8'h40, 32'h0);
		chk({30'h0, bresp_seen}, 32'h2);
		wr(cecr_pkg::OFS_FSSEL, 32'hffff_ffff);
		rchk(cecr_pkg::OFS_FSSEL, 32'h1, 2'h0);
		wr(cecr_pkg::OFS_FSSEL, 32'h0);
		wr(cecr_pkg::OFS_ADDR, 32'h14);
		wr(cecr_pkg::OFS_RCTL3, 32'h1);
		wr(cecr_pkg::OFS_EN, 32'h1);
		$display("registers done");
		u_far.start();
		blk(8'h34, 1'h0, 1'h0);
		rchk(cecr_pkg::OFS_RBUF, 32'h034, 2'h0);
		blk(8'ha5, 1'h1, 1'h0);
		rchk(cecr_pkg::OFS_RBUF, 32'h1a5, 2'h0);
		rchk(cecr_pkg::OFS_FLAGS, 32'h3, 2'h0);
		u_far.block(8'h77, 1'h1);
		chk(n_rx, 2);
		chk(n_st, 1);
		$display("own address done");
		wr(cecr_pkg::OFS_RCTL1, 32'h4000);
		u_far.start();
		blk(8'h32, 1'h0, 1'h0);
		rchk(cecr_pkg::OFS_RBUF, 32'h032, 2'h0);
		blk(8'h5a, 1'h1, 1'h1);
		rchk(cecr_pkg::OFS_RBUF, 32'h35a, 2'h0);
		$display("inhibit done");
		wr(cecr_pkg::OFS_RCTL1, 32'h0);
		wr(cecr_pkg::OFS_RCTL3, 32'h0);
		wr(cecr_pkg::OFS_FLAGS, 32'hff);
		u_far.start();
		blk(8'h37, 1'h1, 1'h1);
		rchk(cecr_pkg::OFS_FLAGS, 32'h2, 2'h0);
		u_far.start();
		blk(8'h3f, 1'h1, 1'h1);
		rchk(cecr_pkg::OFS_RBUF, 32'h33f, 2'h0);
		wr(cecr_pkg::OFS_ADDR, 32'h8014);
		u_far.start();
		blk(8'h3f, 1'h1, 1'h0);
		rchk(cecr_pkg::OFS_RBUF, 32'h13f, 2'h0);
		chk(n_st, 2);
		$display("broadcast done");
		wr(cecr_pkg::OFS_FLAGS, 32'hff);
		u_far.start();
		u_far.send_bit(20, 40);
		u_far.send_bit(20, 79);
		u_far.wait_ticks(120);
		rchk(cecr_pkg::OFS_FLAGS, 32'ha, 2'h0);
		chk(n_err, 1);
		u_far.start();
		blk(8'h34, 1'h1, 1'h0);
		rchk(cecr_pkg::OFS_RBUF, 32'h134, 2'h0);
		$display("short cycle done");
		wr(cecr_pkg::OFS_RCTL1, 32'h8000);
		u_far.start();
		blk(8'h34, 1'h0, 1'h0);
		u_far.block(8'h11, 1'h0);
		chk(n_err, 1);
		blk(8'h22, 1'h1, 1'h1);
		chk(n_err, 2);
		rchk(cecr_pkg::OFS_RBUF, 32'h034, 2'h0);
		$display("error hold done");
		wr(cecr_pkg::OFS_EN, 32'h0);
		wr(cecr_pkg::OFS_FSSEL, 32'h1);
		sel_tm <= 1'h1;
		wr(cecr_pkg::OFS_EN, 32'h1);
		wr(cecr_pkg::OFS_FSSEL, 32'h1);
		wr(cecr_pkg::OFS_RCTL1, 32'h0);
		u_far.start();
		blk(8'h34, 1'h1, 1'h0);
		rchk(cecr_pkg::OFS_RBUF, 32'h134, 2'h0);
		$display("timer clock done");
		give_verdict();
	end
endmodule // tb_top

`default_nettype wire
